// ---- hw/bas_sequencer.sv ----
// batch activity sequencer: one activity at a time, AXI4-Lite registers
// assumes gross_weight comes from logic on aclk; ack and keys are async pins
// What this block does
// - activities test the acknowledge input first, unless the check type is none.
// - ack_check_initial or continuous check with acknowledge missing raises an alarm.
// - wait types hold the activity, without alarm, until acknowledge arrives.
// - after an alarm, alarm reset then restart are both needed to continue.
// - fill shows gross and opens its output if gross is below low level.
// - after the fill output closes, wait the settle time before finishing.
// - fill duration above the timeout value raises a timeout alarm.
// - timeout counting starts at acknowledge and freezes during halts.
// - timeout restarts from zero after timeout alarm reset and restart.
// - timer with output opens its output at acknowledge; plain timer only pauses.
// - timers count the setpoint down and resume the remainder after a halt.
// - at zero the timer closes its output if opened and finishes.
// - latch on opens its output at acknowledge and leaves it open.
// - per-activity hold setting decides if latched outputs stay on during halts.
// - latch off closes its output at acknowledge.
// - manual activity tares the scale then halts batching.
// - with manual print, weight is accumulated and sent to the printer.
// - entry enabled but nothing keyed uses the measured weight.
// - every accepted parameter write from the bus is mirrored to non-volatile storage.
// - only live parameters accept writes while a batch runs.
//
// Design decisions made here: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/10ps
module bas_sequencer #(
	parameter int TICK_CYC = bas_pkg::TICK_CYC_DEF
) (
	// clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// axi4-lite write channels
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// axi4-lite read channels
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// plant side
	input  wire logic        ack_in,
	input  wire logic        restart_key,
	input  wire logic        alarm_reset_key,
	output logic [7:0]       proc_out,
	output logic             alarm_active,
	output logic             busy,
	// weight side
	input  wire logic [31:0] gross_weight,
	output logic             display_gross,
	output logic             tare_req,
	output logic             print_req,
	output logic [31:0]      print_weight,
	// non-volatile parameter store
	output logic             nv_wr,
	output logic [7:0]       nv_addr,
	output logic [31:0]      nv_data,
	input  wire logic        nv_ld_valid,
	input  wire logic [7:0]  nv_ld_addr,
	input  wire logic [31:0] nv_ld_data
);
	import bas_pkg::*;

	// ****************************************
	// pin synchronisers and key edges
	// ****************************************
	logic [2:0] pin_meta_ff, pin_sync_ff, pin_prev_ff;
	wire  [2:0] pin_raw = {alarm_reset_key, restart_key, ack_in};
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_sync
			always_ff @(posedge aclk) begin
				pin_meta_ff[gi] <= aresetn ? pin_raw[gi] : 1'b0;
				pin_sync_ff[gi] <= aresetn ? pin_meta_ff[gi] : 1'b0;
				pin_prev_ff[gi] <= aresetn ? pin_sync_ff[gi] : 1'b0;
			end
		end
	endgenerate
	wire ack_ok    = pin_sync_ff[0];
	wire key_rst   = pin_sync_ff[1] & ~pin_prev_ff[1];
	wire key_arst  = pin_sync_ff[2] & ~pin_prev_ff[2];

	// ****************************************
	// tick divider
	// ****************************************
	logic [31:0] div_ff;
	logic        tick_ff;
	always_ff @(posedge aclk) begin
		if (!aresetn || div_ff == 32'(TICK_CYC - 1)) begin
			div_ff <= 32'h0000_0000;
		end else begin
			div_ff <= div_ff + 32'h0000_0001;
		end
		tick_ff <= aresetn && div_ff == 32'(TICK_CYC - 1);
	end

	// ****************************************
	// axi4-lite slave
	// ****************************************
	logic        awready_ff, wready_ff, bvalid_ff, aw_got_ff, w_got_ff;
	logic        arready_ff, rvalid_ff;
	logic [1:0]  bresp_ff;
	logic [7:0]  awaddr_ff;
	logic [31:0] wdata_ff, rdata_ff;
	logic [3:0]  wstrb_ff;
	bas_state_t  st_ff;
	wire wr_fire   = aw_got_ff & w_got_ff & ~bvalid_ff;
	wire full_strb = wstrb_ff == 4'hF;
	wire idle      = st_ff == ST_IDLE;
	wire is_live   = awaddr_ff == OFS_LOW_LVL || awaddr_ff == OFS_HIGH_LVL ||
	                 awaddr_ff == OFS_TIMER_SP || awaddr_ff == OFS_MAN_WT;
	wire is_param  = is_live || awaddr_ff == OFS_ACT_CFG || awaddr_ff == OFS_SETTLE ||
	                 awaddr_ff == OFS_TIMEOUT;
	wire is_cmd    = awaddr_ff == OFS_CTRL || awaddr_ff == OFS_STATUS;
	wire wr_ok     = full_strb && (is_cmd || (is_param && (is_live || idle)));
	wire bus_wr    = wr_fire && wr_ok && is_param;
	wire ld_wr     = nv_ld_valid && idle && !bus_wr;
	wire         prm_wr   = bus_wr | ld_wr;
	wire [7:0]   prm_addr = bus_wr ? awaddr_ff : nv_ld_addr;
	wire [31:0]  prm_data = bus_wr ? wdata_ff : nv_ld_data;
	wire ctrl_wr   = wr_fire && wr_ok && awaddr_ff == OFS_CTRL;
	wire cmd_start = ctrl_wr && wdata_ff[CTRL_START];
	wire cmd_halt  = ctrl_wr && wdata_ff[CTRL_HALT];
	wire cmd_rst   = (ctrl_wr && wdata_ff[CTRL_RESTRT]) || key_rst;
	wire cmd_arst  = (ctrl_wr && wdata_ff[CTRL_ARST]) || key_arst;
	wire done_clr  = wr_fire && wr_ok && awaddr_ff == OFS_STATUS && wdata_ff[STS_DONE];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready_ff <= 1'b1;
			wready_ff  <= 1'b1;
			aw_got_ff  <= 1'b0;
			w_got_ff   <= 1'b0;
			bvalid_ff  <= 1'b0;
			bresp_ff   <= RESP_OKAY;
			awaddr_ff  <= 8'h00;
			wdata_ff   <= 32'h0000_0000;
			wstrb_ff   <= 4'h0;
		end else if (bvalid_ff && s_axi_bready) begin
			bvalid_ff  <= 1'b0;
			aw_got_ff  <= 1'b0;
			w_got_ff   <= 1'b0;
			awready_ff <= 1'b1;
			wready_ff  <= 1'b1;
		end else begin
			if (s_axi_awvalid && awready_ff) begin
				aw_got_ff  <= 1'b1;
				awready_ff <= 1'b0;
				awaddr_ff  <= {s_axi_awaddr[7:2], 2'h0};
			end
			if (s_axi_wvalid && wready_ff) begin
				w_got_ff  <= 1'b1;
				wready_ff <= 1'b0;
				wdata_ff  <= s_axi_wdata;
				wstrb_ff  <= s_axi_wstrb;
			end
			if (wr_fire) begin
				bvalid_ff <= 1'b1;
				bresp_ff  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
			end
		end
	end

	// ****************************************
	// parameter registers and nv mirror
	// ****************************************
	logic [31:0] cfg_ff, low_ff, high_ff, settle_sp_ff, tmo_sp_ff, timer_sp_ff, man_wt_ff;
	logic        man_vld_ff, nv_wr_ff;
	logic [7:0]  nv_addr_ff;
	logic [31:0] nv_data_ff;
	logic        man_used;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cfg_ff       <= RST_CFG;
			low_ff       <= RST_LEVEL;
			high_ff      <= RST_LEVEL;
			settle_sp_ff <= RST_TIME;
			tmo_sp_ff    <= RST_TIME;
			timer_sp_ff  <= RST_TIME;
			man_wt_ff    <= RST_LEVEL;
			man_vld_ff   <= 1'b0;
		end else begin
			if (prm_wr && prm_addr == OFS_ACT_CFG)  cfg_ff       <= prm_data;
			if (prm_wr && prm_addr == OFS_LOW_LVL)  low_ff       <= prm_data;
			if (prm_wr && prm_addr == OFS_HIGH_LVL) high_ff      <= prm_data;
			if (prm_wr && prm_addr == OFS_SETTLE)   settle_sp_ff <= prm_data;
			if (prm_wr && prm_addr == OFS_TIMEOUT)  tmo_sp_ff    <= prm_data;
			if (prm_wr && prm_addr == OFS_TIMER_SP) timer_sp_ff  <= prm_data;
			if (prm_wr && prm_addr == OFS_MAN_WT)   man_wt_ff    <= prm_data;
			man_vld_ff <= (prm_wr && prm_addr == OFS_MAN_WT) || (man_vld_ff && !man_used);
		end
		nv_wr_ff   <= aresetn && bus_wr;
		nv_addr_ff <= aresetn ? awaddr_ff : 8'h00;
		nv_data_ff <= aresetn ? wdata_ff : 32'h0000_0000;
	end

	// ****************************************
	// activity decode
	// ****************************************
	wire bas_act_t act    = bas_act_t'(cfg_ff[CFG_TYPE_LO +: 3]);
	wire bas_ack_t ackm   = bas_ack_t'(cfg_ff[CFG_ACK_LO +: 3]);
	wire [2:0]     osel   = cfg_ff[CFG_OUT_LO +: 3];
	wire ack_go     = ackm == ACK_NONE || ack_ok;
	wire ack_alarm  = (ackm == ack_check_initial || ackm == ACK_CONT) && !ack_ok;
	wire cont_alarm = ackm == ACK_CONT && !ack_ok;
	wire run_ok     = !(ackm == ACK_WAIT_CONT && !ack_ok);
	wire below_low  = $signed(gross_weight) < $signed(low_ff);
	wire at_high    = $signed(gross_weight) >= $signed(high_ff);
	wire halted     = st_ff == ST_HALT || st_ff == ST_ALARM || st_ff == ST_ARST;

	// ****************************************
	// sequencer state
	// ****************************************
	bas_state_t  resume_ff, nxt_st, nxt_resume;
	bas_cause_t  cause_ff, nxt_cause;
	logic [7:0]  out_ff, hold_ff, nxt_out, nxt_hold, proc_out_ff;
	logic [31:0] tmo_ff, tcnt_ff, settle_ff, accum_ff, pw_ff, nxt_tmo, nxt_tcnt, nxt_settle;
	logic [31:0] nxt_accum, nxt_pw;
	logic        disp_ff, tare_ff, print_ff, done_ff, busy_ff, alarm_ff;
	logic        nxt_disp, nxt_tare, nxt_print;
	wire  [31:0] man_wt   = (cfg_ff[CFG_ENTER] && man_vld_ff) ? man_wt_ff : gross_weight;
	wire         tmo_over = tmo_ff > tmo_sp_ff;

	always_comb begin
		nxt_st     = st_ff;
		nxt_resume = resume_ff;
		nxt_cause  = cause_ff;
		nxt_out    = out_ff;
		nxt_hold   = hold_ff;
		nxt_tmo    = tmo_ff;
		nxt_tcnt   = tcnt_ff;
		nxt_settle = settle_ff;
		nxt_accum  = accum_ff;
		nxt_pw     = pw_ff;
		nxt_disp   = disp_ff;
		nxt_tare   = 1'b0;
		nxt_print  = 1'b0;
		man_used   = 1'b0;
		case (st_ff)
			ST_IDLE: if (cmd_start) begin
				nxt_st   = ST_ACK;
				nxt_tmo  = 32'h0000_0000;
				nxt_tcnt = timer_sp_ff;
			end
			ST_ACK: if (ack_alarm) begin
				nxt_st     = ST_ALARM;
				nxt_cause  = CAUSE_ACK;
				nxt_resume = ST_ACK;
			end else if (ack_go) begin
				nxt_st = ST_DONE;
				case (act)
					ACT_FILL: if (below_low) begin
						nxt_disp          = 1'b1;
						nxt_out[osel]     = 1'b1;
						nxt_hold[osel]    = 1'b0;
						nxt_st            = ST_ACT;
					end
					ACT_TIMER, ACT_TIMER_OUT: begin
						nxt_out[osel]  = act == ACT_TIMER_OUT || out_ff[osel];
						nxt_hold[osel] = act == ACT_TIMER_OUT ? 1'b0 : hold_ff[osel];
						nxt_st         = ST_ACT;
					end
					ACT_LATCH_ON: begin
						nxt_out[osel]  = 1'b1;
						nxt_hold[osel] = cfg_ff[CFG_HOLD];
					end
					ACT_LATCH_OFF: nxt_out[osel] = 1'b0;
					ACT_MANUAL: begin
						nxt_tare   = 1'b1;
						man_used   = 1'b1;
						nxt_st     = ST_HALT;
						nxt_resume = ST_DONE;
						if (cfg_ff[CFG_PRINT]) begin
							nxt_accum = accum_ff + man_wt;
							nxt_pw    = man_wt;
							nxt_print = 1'b1;
						end
					end
					default: nxt_st = ST_DONE;
				endcase
			end
			ST_ACT, ST_SETTLE: if (cont_alarm || tmo_over) begin
				nxt_st     = ST_ALARM;
				nxt_cause  = cont_alarm ? CAUSE_ACK : CAUSE_TMO;
				nxt_resume = st_ff;
			end else if (cmd_halt) begin
				nxt_st     = ST_HALT;
				nxt_resume = st_ff;
			end else if (run_ok) begin
				if (tick_ff && act == ACT_FILL) nxt_tmo = tmo_ff + 32'h0000_0001;
				if (st_ff == ST_SETTLE) begin
					if (settle_ff == 32'h0000_0000) nxt_st = ST_DONE;
					else if (tick_ff) nxt_settle = settle_ff - 32'h0000_0001;
				end else if (act == ACT_FILL) begin
					if (at_high) begin
						nxt_out[osel] = 1'b0;
						nxt_settle    = settle_sp_ff;
						nxt_st        = ST_SETTLE;
					end
				end else if (tick_ff) begin
					if (tcnt_ff == 32'h0000_0000) begin
						nxt_out[osel] = act == ACT_TIMER_OUT ? 1'b0 : out_ff[osel];
						nxt_st        = ST_DONE;
					end else begin
						nxt_tcnt = tcnt_ff - 32'h0000_0001;
					end
				end
			end
			ST_DONE: nxt_st = ST_IDLE;
			ST_ALARM: if (cmd_arst) nxt_st = ST_ARST;
			ST_ARST: if (cmd_rst) begin
				nxt_st    = resume_ff;
				nxt_cause = CAUSE_NONE;
				if (cause_ff == CAUSE_TMO) nxt_tmo = 32'h0000_0000;
			end
			ST_HALT: if (cmd_rst) nxt_st = resume_ff;
			default: nxt_st = ST_IDLE;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_ff     <= ST_IDLE;
			resume_ff <= ST_IDLE;
			cause_ff  <= CAUSE_NONE;
			out_ff    <= 8'h00;
			hold_ff   <= 8'h00;
			tmo_ff    <= 32'h0000_0000;
			tcnt_ff   <= 32'h0000_0000;
			settle_ff <= 32'h0000_0000;
			accum_ff  <= 32'h0000_0000;
			pw_ff     <= 32'h0000_0000;
			disp_ff   <= 1'b0;
			tare_ff   <= 1'b0;
			print_ff  <= 1'b0;
			done_ff   <= 1'b0;
			busy_ff   <= 1'b0;
			alarm_ff  <= 1'b0;
		end else begin
			st_ff     <= nxt_st;
			resume_ff <= nxt_resume;
			cause_ff  <= nxt_cause;
			out_ff    <= nxt_out;
			hold_ff   <= nxt_hold;
			tmo_ff    <= nxt_tmo;
			tcnt_ff   <= nxt_tcnt;
			settle_ff <= nxt_settle;
			accum_ff  <= nxt_accum;
			pw_ff     <= nxt_pw;
			disp_ff   <= nxt_disp;
			tare_ff   <= nxt_tare;
			print_ff  <= nxt_print;
			busy_ff   <= nxt_st != ST_IDLE;
			alarm_ff  <= nxt_cause != CAUSE_NONE;
			// a completion in the clearing cycle still sets the flag
			done_ff   <= (st_ff == ST_DONE) || (done_ff && !done_clr);
		end
	end

	// ****************************************
	// output gating during halts
	// ****************************************
	generate
		for (gi = 0; gi < 8; gi++) begin : g_out
			always_ff @(posedge aclk) begin
				proc_out_ff[gi] <= aresetn && out_ff[gi] && (!halted || hold_ff[gi]);
			end
		end
	endgenerate

	// ****************************************
	// read path
	// ****************************************
	wire [31:0] status_w = {23'h0, done_ff, 2'h0, cause_ff, alarm_active, st_ff};
	wire [31:0] rd_mux =
		s_axi_araddr[7:2] == OFS_STATUS[7:2]   ? status_w :
		s_axi_araddr[7:2] == OFS_ACT_CFG[7:2]  ? cfg_ff :
		s_axi_araddr[7:2] == OFS_LOW_LVL[7:2]  ? low_ff :
		s_axi_araddr[7:2] == OFS_HIGH_LVL[7:2] ? high_ff :
		s_axi_araddr[7:2] == OFS_SETTLE[7:2]   ? settle_sp_ff :
		s_axi_araddr[7:2] == OFS_TIMEOUT[7:2]  ? tmo_sp_ff :
		s_axi_araddr[7:2] == OFS_TIMER_SP[7:2] ? timer_sp_ff :
		s_axi_araddr[7:2] == OFS_MAN_WT[7:2]   ? man_wt_ff :
		s_axi_araddr[7:2] == OFS_TMO_CNT[7:2]  ? tmo_ff :
		s_axi_araddr[7:2] == OFS_TMR_CNT[7:2]  ? tcnt_ff :
		s_axi_araddr[7:2] == OFS_ACCUM[7:2]    ? accum_ff : 32'h0000_0000;
	wire rd_map = s_axi_araddr[7:2] != OFS_CTRL[7:2] && s_axi_araddr <= OFS_ACCUM + 8'h03;
	logic [1:0] rresp_ff;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_ff <= 1'b1;
			rvalid_ff  <= 1'b0;
			rdata_ff   <= 32'h0000_0000;
			rresp_ff   <= RESP_OKAY;
		end else if (s_axi_arvalid && arready_ff) begin
			arready_ff <= 1'b0;
			rvalid_ff  <= 1'b1;
			rdata_ff   <= rd_map ? rd_mux : 32'h0000_0000;
			rresp_ff   <= rd_map ? RESP_OKAY : RESP_SLVERR;
		end else if (rvalid_ff && s_axi_rready) begin
			rvalid_ff  <= 1'b0;
			arready_ff <= 1'b1;
		end
	end

	assign s_axi_awready = awready_ff;
	assign s_axi_wready  = wready_ff;
	assign s_axi_bvalid  = bvalid_ff;
	assign s_axi_bresp   = bresp_ff;
	assign s_axi_arready = arready_ff;
	assign s_axi_rvalid  = rvalid_ff;
	assign s_axi_rdata   = rdata_ff;
	assign s_axi_rresp   = rresp_ff;
	assign proc_out      = proc_out_ff;
	assign alarm_active  = alarm_ff;
	assign busy          = busy_ff;
	assign display_gross = disp_ff;
	assign tare_req      = tare_ff;
	assign print_req     = print_ff;
	assign print_weight  = pw_ff;
	assign nv_wr         = nv_wr_ff;
	assign nv_addr       = nv_addr_ff;
	assign nv_data       = nv_data_ff;

	// ****************************************
	// assertions
	// ****************************************
	property p_ack_alarm;
		@(posedge aclk) disable iff (!aresetn)
		(st_ff == ST_ACK && ackm == ack_check_initial && !ack_ok) |=> st_ff == ST_ALARM;
	endproperty
	a_ack_alarm: assert property (p_ack_alarm) else $error("missing ack did not alarm");
	property p_ack_wait;
		@(posedge aclk) disable iff (!aresetn)
		(st_ff == ST_ACK && ackm == ACK_WAIT && !ack_ok) |=> st_ff == ST_ACK && !alarm_active;
	endproperty
	a_ack_wait: assert property (p_ack_wait) else $error("wait type left ack state");
	property p_fill_start;
		@(posedge aclk) disable iff (!aresetn)
		(st_ff == ST_ACK && act == ACT_FILL && !ack_alarm && ack_go && below_low)
		|=> out_ff[$past(osel)] && display_gross ##1 proc_out[$past(osel, 2)];
	endproperty
	a_fill_start: assert property (p_fill_start) else $error("fill output not opened");
	property p_fill_stop;
		@(posedge aclk) disable iff (!aresetn)
		(st_ff == ST_ACT && act == ACT_FILL && at_high && run_ok && !cont_alarm && !tmo_over
		 && !cmd_halt) |=> st_ff == ST_SETTLE && !out_ff[$past(osel)];
	endproperty
	a_fill_stop: assert property (p_fill_stop) else $error("fill output not closed");
	property p_timeout;
		@(posedge aclk) disable iff (!aresetn)
		((st_ff == ST_ACT || st_ff == ST_SETTLE) && tmo_over)
		|=> st_ff == ST_ALARM && alarm_active;
	endproperty
	a_timeout: assert property (p_timeout) else $error("timeout not alarmed");
	property p_tmo_frozen;
		@(posedge aclk) disable iff (!aresetn)
		(st_ff == ST_ALARM || st_ff == ST_HALT) |=> $stable(tmo_ff);
	endproperty
	a_tmo_frozen: assert property (p_tmo_frozen) else $error("timeout moved in halt");
	property p_tmo_restart;
		@(posedge aclk) disable iff (!aresetn)
		(st_ff == ST_ARST && cmd_rst && cause_ff == CAUSE_TMO) |=> tmo_ff == 32'h0000_0000;
	endproperty
	a_tmo_restart: assert property (p_tmo_restart) else $error("timeout not cleared");
	property p_timer_dec;
		@(posedge aclk) disable iff (!aresetn)
		(st_ff == ST_ACT && act != ACT_FILL && tick_ff && run_ok && !cont_alarm && !cmd_halt
		 && tcnt_ff != 32'h0000_0000) |=> tcnt_ff == $past(tcnt_ff) - 32'h0000_0001;
	endproperty
	a_timer_dec: assert property (p_timer_dec) else $error("timer did not count");
	property p_timer_end;
		@(posedge aclk) disable iff (!aresetn)
		(st_ff == ST_ACT && act == ACT_TIMER_OUT && tick_ff && run_ok && !cont_alarm
		 && !cmd_halt && tcnt_ff == 32'h0000_0000) |=> st_ff == ST_DONE ##1 st_ff == ST_IDLE;
	endproperty
	a_timer_end: assert property (p_timer_end) else $error("timer did not finish");
	property p_halt_off;
		@(posedge aclk) disable iff (!aresetn)
		halted |=> (proc_out & ~$past(hold_ff)) == 8'h00;
	endproperty
	a_halt_off: assert property (p_halt_off) else $error("output on during halt");

endmodule // bas_sequencer

// ---- shared/bas_pkg.sv ----
// constants, field layouts and enumerations of the batch activity sequencer
// assumes a single 100 MHz clock and 32-bit AXI4-Lite register access
package bas_pkg;

	// ****************************************
	// timing
	// ****************************************
	localparam int CLK_PERIOD_NS  = 10;
	localparam int TICK_PERIOD_NS = 1000000;
	localparam int TICK_CYC_DEF   = TICK_PERIOD_NS / CLK_PERIOD_NS;

	// ****************************************
	// register byte offsets
	// ****************************************
	localparam logic [7:0] OFS_CTRL     = 8'h00;
	localparam logic [7:0] OFS_STATUS   = 8'h04;
	localparam logic [7:0] OFS_ACT_CFG  = 8'h08;
	localparam logic [7:0] OFS_LOW_LVL  = 8'h0C;
	localparam logic [7:0] OFS_HIGH_LVL = 8'h10;
	localparam logic [7:0] OFS_SETTLE   = 8'h14;
	localparam logic [7:0] OFS_TIMEOUT  = 8'h18;
	localparam logic [7:0] OFS_TIMER_SP = 8'h1C;
	localparam logic [7:0] OFS_MAN_WT   = 8'h20;
	localparam logic [7:0] OFS_TMO_CNT  = 8'h24;
	localparam logic [7:0] OFS_TMR_CNT  = 8'h28;
	localparam logic [7:0] OFS_ACCUM    = 8'h2C;

	// ****************************************
	// field positions
	// ****************************************
	localparam int CTRL_START  = 0;
	localparam int CTRL_HALT   = 1;
	localparam int CTRL_RESTRT = 2;
	localparam int CTRL_ARST   = 3;
	localparam int CFG_TYPE_LO = 0;
	localparam int CFG_ACK_LO  = 4;
	localparam int CFG_OUT_LO  = 8;
	localparam int CFG_HOLD    = 12;
	localparam int CFG_PRINT   = 13;
	localparam int CFG_ENTER   = 14;
	localparam int STS_DONE    = 8;

	// ****************************************
	// reset values and bus response codes
	// ****************************************
	localparam logic [31:0] RST_CFG     = 32'h0000_0000;
	localparam logic [31:0] RST_LEVEL   = 32'h0000_0000;
	localparam logic [31:0] RST_TIME    = 32'h0000_0000;
	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;

	// ****************************************
	// enumerations
	// ****************************************
	typedef enum logic [2:0] {
		ST_IDLE   = 3'h0,
		ST_ACK    = 3'h1,
		ST_ACT    = 3'h3,
		ST_SETTLE = 3'h2,
		ST_DONE   = 3'h6,
		ST_ALARM  = 3'h7,
		ST_ARST   = 3'h5,
		ST_HALT   = 3'h4
	} bas_state_t;

	typedef enum logic [2:0] {
		ACT_FILL = 3'h0, ACT_TIMER = 3'h1, ACT_TIMER_OUT = 3'h2,
		ACT_LATCH_ON = 3'h3, ACT_LATCH_OFF = 3'h4, ACT_MANUAL = 3'h5
	} bas_act_t;

	typedef enum logic [2:0] {
		ACK_NONE = 3'h0, ack_check_initial = 3'h1, ACK_CONT = 3'h2,
		ACK_WAIT = 3'h3, ACK_WAIT_CONT = 3'h4
	} bas_ack_t;

	typedef enum logic [1:0] {
		CAUSE_NONE = 2'h0, CAUSE_ACK = 2'h1, CAUSE_TMO = 2'h2
	} bas_cause_t;

endpackage

// ---- sim/bas_plant_model.sv ----
// plant side: acknowledge pin and operator keys
// assumes one key request pulse from the bench per press
`timescale 1ns/10ps
module bas_plant_model (
	input  wire logic       aclk,
	input  wire logic       ack_lvl,
	input  wire logic [1:0] key,
	output logic            ack_in,
	output logic            alarm_reset_key,
	output logic            restart_key
);
	logic [2:0] cnt_ff = 3'h0;
	logic       sel_ff = 1'b0;
	// a press holds the pin long enough to pass the synchroniser
	always_ff @(posedge aclk) begin
		if (key != 2'h0) begin
			cnt_ff <= 3'h4;
			sel_ff <= key[1];
		end else if (cnt_ff != 3'h0)
			cnt_ff <= cnt_ff - 3'h1;
	end
	assign restart_key     = (cnt_ff != 3'h0) & sel_ff;
	assign alarm_reset_key = (cnt_ff != 3'h0) & ~sel_ff;
	assign ack_in          = ack_lvl;
endmodule // bas_plant_model

// ---- sim/batch_activity_sequencer_tb.sv ----
// bench: bus tasks, fill, alarm and manual runs
// assumes bas_pkg and bas_sequencer compiled first
`timescale 1ns/10ps
module batch_activity_sequencer_tb;
	import bas_pkg::*;
	logic aclk = 0, aresetn = 0, awv = 0, wv = 0, bready = 0, arv = 0, rready = 0, ack = 0, nvl = 0;
	logic [7:0] awaddr = 0, araddr = 0, proc_out, nv_addr, nvla = 0;
	logic [31:0] wdata = 0, gross = 0, rdata, pw, nv_data, rd_v, nvld = 0;
	logic [1:0] bresp, rresp, key = 0;
	logic awr, wr_, bv, arr, rv, ackp, rk, ak, alm, busy, dg, tare, prq, nvw;
	int num_errors = 0, n_tests = 0;
	bas_sequencer #(.TICK_CYC(4)) i_dut (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awv), .s_axi_awready(awr),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wr_),
		.s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arv), .s_axi_arready(arr),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rready),
		.ack_in(ackp), .restart_key(rk), .alarm_reset_key(ak), .proc_out(proc_out),
		.alarm_active(alm), .busy(busy), .gross_weight(gross), .display_gross(dg),
		.tare_req(tare), .print_req(prq), .print_weight(pw), .nv_wr(nvw),
		.nv_addr(nv_addr), .nv_data(nv_data), .nv_ld_valid(nvl), .nv_ld_addr(nvla),
		.nv_ld_data(nvld));
	bas_plant_model i_plant (.aclk(aclk), .ack_lvl(ack), .key(key), .ack_in(ackp),
		.alarm_reset_key(ak), .restart_key(rk));
	initial forever #5 aclk = ~aclk;
	task automatic report_and_stop();
		$display("tests %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		n_tests++;
		if (s !== e) begin
			num_errors++;
			$display("mismatch %s exp %h got %h", nm, e, s);
		end
	endtask
	task automatic tmo(input int n);
		if (n >= 200) begin
			num_errors++;
			$display("mismatch wait timeout");
			report_and_stop();
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		int n;
		logic ta, tw;
		n = 0; ta = 0; tw = 0;
		awaddr <= a; wdata <= d; awv <= 1; wv <= 1;
		while (!(ta && tw) && n < 200) begin
			@(posedge aclk); n++;
			if (awv && awr === 1'b1) begin ta = 1; awv <= 0; end
			if (wv && wr_ === 1'b1) begin tw = 1; wv <= 0; end
		end
		bready <= 1;
		do begin @(posedge aclk); n++; end while (bv !== 1'b1 && n < 200);
		bready <= 0; tmo(n);
		chk("bresp", er, bresp);
	endtask
	task automatic rd(input logic [7:0] a, input logic [1:0] er);
		int n;
		n = 0;
		araddr <= a; arv <= 1;
		do begin @(posedge aclk); n++; end while (arr !== 1'b1 && n < 200);
		arv <= 0; rready <= 1;
		do begin @(posedge aclk); n++; end while (rv !== 1'b1 && n < 200);
		rready <= 0; tmo(n); rd_v = rdata;
		chk("rresp", er, rresp);
	endtask
	task automatic press(input logic [1:0] k);
		key <= k; @(posedge aclk); key <= 0;
		repeat (8) @(posedge aclk);
	endtask
	task automatic wait_idle();
		int n;
		n = 0;
		while (busy !== 1'b0 && n < 200) begin @(posedge aclk); n++; end
		tmo(n);
	endtask
	task automatic t_regs();
		rd(OFS_STATUS, RESP_OKAY); chk("status", 32'h0, rd_v);
		rd(8'h30, RESP_SLVERR); chk("unmapped", 32'h0, rd_v);
		rd(OFS_CTRL, RESP_SLVERR);
		nvla <= OFS_TIMER_SP; nvld <= 32'd5; nvl <= 1; @(posedge aclk); nvl <= 0;
		rd(OFS_TIMER_SP, RESP_OKAY); chk("restore", 32'd5, rd_v);
		$display("test regs done");
	endtask
	task automatic t_fill();
		wr(OFS_LOW_LVL, 32'd100, RESP_OKAY); wr(OFS_HIGH_LVL, 32'd200, RESP_OKAY);
		wr(OFS_SETTLE, 32'd3, RESP_OKAY); wr(OFS_ACT_CFG, 32'h0000_0200, RESP_OKAY);
		wr(OFS_TIMEOUT, 32'd100, RESP_OKAY);
		gross <= 32'd50; wr(OFS_CTRL, 32'h1, RESP_OKAY);
		repeat (4) @(posedge aclk);
		chk("fill_out", 8'h04, proc_out);
		chk("gross_disp", 1'b1, dg);
		wr(OFS_SETTLE, 32'd1, RESP_SLVERR);
		chk("nv_refused", 32'h0, nvw);
		wr(OFS_LOW_LVL, 32'd100, RESP_OKAY);
		chk("nv_wr", 32'h1, nvw); chk("nv_data", 32'd100, nv_data);
		gross <= 32'd200; repeat (4) @(posedge aclk);
		chk("fill_stop", 8'h00, proc_out);
		chk("settling", 1'b1, busy);
		wait_idle(); rd(OFS_STATUS, RESP_OKAY);
		chk("done", 32'h100, rd_v);
		wr(OFS_STATUS, 32'h100, RESP_OKAY); rd(OFS_STATUS, RESP_OKAY);
		chk("done_clr", 32'h0, rd_v);
		$display("test fill done");
	endtask
	task automatic t_tmo();
		wr(OFS_TIMEOUT, 32'd1, RESP_OKAY); wr(OFS_SETTLE, 32'd0, RESP_OKAY);
		gross <= 32'd50; wr(OFS_CTRL, 32'h1, RESP_OKAY); repeat (12) @(posedge aclk);
		chk("tmo_alarm", 32'h1, alm);
		chk("tmo_out_off", 8'h00, proc_out);
		rd(OFS_STATUS, RESP_OKAY); chk("tmo_cause", 32'h2F, rd_v);
		gross <= 32'd200; press(2'h1); press(2'h2);
		chk("tmo_clear", 32'h0, alm); chk("tmo_done", 32'h0, busy);
		$display("test timeout done");
	endtask
	task automatic t_alarm();
		wr(OFS_TIMER_SP, 32'd3, RESP_OKAY); wr(OFS_ACT_CFG, 32'h0000_0112, RESP_OKAY);
		wr(OFS_CTRL, 32'h1, RESP_OKAY); repeat (4) @(posedge aclk);
		chk("ack_alarm", 1'b1, alm);
		chk("no_out", 8'h00, proc_out);
		ack <= 1; press(2'h2);
		chk("restart_only", 1'b1, alm);
		press(2'h1); press(2'h2);
		chk("alarm_clr", 1'b0, alm);
		chk("timer_out", 8'h02, proc_out);
		wait_idle(); chk("timer_end", 8'h00, proc_out);
		ack <= 0; wr(OFS_ACT_CFG, 32'h0000_1333, RESP_OKAY); wr(OFS_CTRL, 32'h1, RESP_OKAY);
		repeat (6) @(posedge aclk);
		chk("ack_wait", 32'h1, busy); chk("wait_no_alarm", 32'h0, alm);
		ack <= 1; wait_idle(); chk("latch_on", 8'h08, proc_out);
		$display("test alarm done");
	endtask
	task automatic t_manual();
		wr(OFS_ACT_CFG, 32'h0000_6005, RESP_OKAY); gross <= 32'd77;
		wr(OFS_CTRL, 32'h1, RESP_OKAY); @(posedge aclk);
		chk("tare", 32'h1, tare);
		chk("print", 32'h1, prq);
		repeat (19) @(posedge aclk);
		chk("held", 1'b1, busy);
		chk("held_out", 8'h08, proc_out);
		chk("print_wt", 32'd77, pw);
		press(2'h2); wait_idle();
		rd(OFS_ACCUM, RESP_OKAY); chk("accum", 32'd77, rd_v);
		$display("test manual done");
	endtask
	initial begin
		repeat (2) @(posedge aclk);
		aresetn <= 1;
		t_regs();
		t_fill();
		t_tmo();
		t_alarm();
		t_manual();
		report_and_stop();
	end
endmodule // batch_activity_sequencer_tb
